//--- rtl/safe_stop_input.sv
// dual-channel safe stop input monitor for one drive
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// Functional notes
// - high input deselects the stop, low input selects it
// - channels disagreeing past tolerance raise a lowest-severity discrepancy fault
// - selection on either channel removes pulses at once
// - terminal sampled on a controller-cycle multiple, never faster than 1 ms
// - up to 12 first-channel inputs ANDed for parallel power units
// - AND width equals configured parallel component count
// - per-channel adjustable filter suppresses short test pulses; selection here also reacts to the unfiltered inputs
// - first-channel input chosen from any digital input
// - selection and faults act on this drive only
// - incompatible version at mode 95 raises alignment fault, coast-down reaction
// - alignment fault cannot be cleared while mode 95 is active
// - incompatibility forces pulse suppression and brake closing if configured
// - incompatibility blocks enabling torque-off and brake functions
// - checksum mismatch raises acceptance fault value 1000
// - configuration download raises acceptance fault value 2004
// - activating settings updates reference checksum automatically
// - with brake enabled, every selection closes brake and tests brake path
// - evaluation runs once per safety monitoring cycle
module safe_stop_input
  import safe_stop_pkg::*;
#(
  parameter int unsigned PARALLEL_MAX = MAX_PARALLEL,
  parameter int unsigned DIN_WIDTH    = DIN_COUNT
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [DIN_WIDTH-1:0] digital_inputs,
  input  wire logic                 enable_pulses_terminal,
  input  wire logic                 monitor_tick,
  input  wire logic                 current_ctrl_tick,
  input  wire logic                 version_incompatible,
  input  wire logic                 config_download,
  input  wire logic [3:0]           addr,
  input  wire logic [15:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output stop_out_t                 stop_out,
  output logic [15:0]               rdata
);
  localparam int unsigned SEL_W = $clog2(DIN_WIDTH);

  if (PARALLEL_MAX < 1 || PARALLEL_MAX > MAX_PARALLEL || DIN_WIDTH < 2) begin : g_bad_params
    $error("unsupported parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [5:0]        function_enable, next_function_enable;
  logic [15:0]       ctrl_changeover_tolerance, next_ctrl_changeover_tolerance;
  logic [15:0]       power_changeover_tolerance, next_power_changeover_tolerance;
  logic [7:0]        ctrl_input_filter_time, next_ctrl_input_filter_time;
  logic [7:0]        power_input_filter_time, next_power_input_filter_time;
  logic [7:0]        commissioning_mode_select, next_commissioning_mode_select;
  logic [7:0]        sample_div, next_sample_div;
  logic [3:0]        parallel_component_count, next_parallel_component_count;
  logic [SEL_W-1:0]  first_path_input_select [PARALLEL_MAX];
  logic [SEL_W-1:0]  next_first_path_input_select [PARALLEL_MAX];
  logic [15:0]       power_reference_checksum, next_power_reference_checksum;
  logic [15:0]       power_actual_checksum;
  logic [15:0]       accept_value, next_accept_value;
  logic              monitor_alignment_fault, next_monitor_alignment_fault;
  logic              ctrl_fault, power_fault;
  logic [15:0]       next_rdata;
  logic              commissioning;
  logic              ack_wr;

  assign commissioning = (commissioning_mode_select == COMMISSION_CODE);
  assign ack_wr        = wr && addr == ADDR_ACK;
  assign power_actual_checksum = {ctrl_changeover_tolerance ^ power_changeover_tolerance}
                                 ^ {8'h00, function_enable, 2'b00};

  always_comb begin
    next_function_enable            = function_enable;
    next_ctrl_changeover_tolerance  = ctrl_changeover_tolerance;
    next_power_changeover_tolerance = power_changeover_tolerance;
    next_ctrl_input_filter_time     = ctrl_input_filter_time;
    next_power_input_filter_time    = power_input_filter_time;
    next_commissioning_mode_select  = commissioning_mode_select;
    next_sample_div                 = sample_div;
    next_parallel_component_count   = parallel_component_count;
    next_power_reference_checksum   = power_reference_checksum;
    next_accept_value               = accept_value;
    next_first_path_input_select    = first_path_input_select;
    if (wr) begin
      case (addr)
        ADDR_FUNC_ENABLE: begin
          if (version_incompatible)
            next_function_enable = wdata[5:0] & 6'h30;
          else
            next_function_enable = wdata[5:0];
        end
        ADDR_CTRL_TOL:   next_ctrl_changeover_tolerance  = wdata;
        ADDR_POWER_TOL:  next_power_changeover_tolerance = wdata;
        ADDR_CTRL_FILT:  next_ctrl_input_filter_time     = wdata[7:0];
        ADDR_POWER_FILT: next_power_input_filter_time    = wdata[7:0];
        ADDR_MODE:       next_commissioning_mode_select  = wdata[7:0];
        ADDR_SAMPLE_DIV: next_sample_div                 = wdata[7:0];
        ADDR_SELECT_BASE:
          if (wdata[15:12] < PARALLEL_MAX && wdata[SEL_W-1:0] < DIN_WIDTH)
            next_first_path_input_select[wdata[15:12]] = wdata[SEL_W-1:0];
        ADDR_PARALLEL:
          if (wdata[3:0] >= 4'h1 && wdata[3:0] <= 4'(PARALLEL_MAX))
            next_parallel_component_count = wdata[3:0];
        ADDR_CHECKSUM:   if (commissioning) next_power_reference_checksum = wdata;
        default: ;
      endcase
    end
    if (version_incompatible)
      next_function_enable = next_function_enable & 6'h30;
    // reference follows the configuration that is being activated
    if (wr && addr == ADDR_FUNC_ENABLE && wdata[EN_ACTIVATE])
      next_power_reference_checksum = (next_ctrl_changeover_tolerance
                                       ^ next_power_changeover_tolerance)
                                      ^ {8'h00, next_function_enable, 2'b00};
    // checksum mismatch outranks the download notice
    if (config_download)
      next_accept_value = DOWNLOAD_FAULT_VAL;
    else if (ack_wr && wdata[ACK_DOWNLOAD])
      next_accept_value = NO_FAULT_VAL;
    if (power_reference_checksum != power_actual_checksum)
      next_accept_value = CHECKSUM_FAULT_VAL;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      function_enable            <= FUNC_RST;
      ctrl_changeover_tolerance  <= 16'h0000;
      power_changeover_tolerance <= 16'h0000;
      ctrl_input_filter_time     <= 8'h00;
      power_input_filter_time    <= 8'h00;
      commissioning_mode_select  <= 8'h00;
      sample_div                 <= 8'h01;
      parallel_component_count   <= 4'h1;
      power_reference_checksum   <= 16'h0000;
      accept_value               <= NO_FAULT_VAL;
      for (int i = 0; i < PARALLEL_MAX; i++) first_path_input_select[i] <= '0;
    end else begin
      function_enable            <= next_function_enable;
      ctrl_changeover_tolerance  <= next_ctrl_changeover_tolerance;
      power_changeover_tolerance <= next_power_changeover_tolerance;
      ctrl_input_filter_time     <= next_ctrl_input_filter_time;
      power_input_filter_time    <= next_power_input_filter_time;
      commissioning_mode_select  <= next_commissioning_mode_select;
      sample_div                 <= next_sample_div;
      parallel_component_count   <= next_parallel_component_count;
      power_reference_checksum   <= next_power_reference_checksum;
      accept_value               <= next_accept_value;
      first_path_input_select    <= next_first_path_input_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first channel: selectable inputs ANDed over the parallel group
  logic [PARALLEL_MAX-1:0] and_terms;
  logic                    ctrl_raw;
  genvar g;
  generate
    for (g = 0; g < PARALLEL_MAX; g++) begin : g_and
      assign and_terms[g] = (g >= parallel_component_count) ? 1'b1
                          : digital_inputs[first_path_input_select[g]];
    end
  endgenerate
  assign ctrl_raw = &and_terms;

  ////////////////////////////////////////////////////////////////////////////
  // second channel: terminal sampled on a current-controller-cycle multiple
  logic [7:0]  cyc_cnt, next_cyc_cnt;
  logic [15:0] us_cnt, next_us_cnt;
  logic        power_raw, next_power_raw;

  always_comb begin
    next_cyc_cnt   = cyc_cnt;
    next_us_cnt    = (us_cnt == 16'hffff) ? us_cnt : us_cnt + 16'h0001;
    next_power_raw = power_raw;
    if (current_ctrl_tick) begin
      next_cyc_cnt = cyc_cnt + 8'h01;
      if (cyc_cnt + 8'h01 >= sample_div && us_cnt >= 16'(MIN_SAMPLE_CYCLES)) begin
        next_power_raw = enable_pulses_terminal;
        next_cyc_cnt   = 8'h00;
        next_us_cnt    = 16'h0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_cnt   <= 8'h00;
      us_cnt    <= 16'h0000;
      power_raw <= 1'b0;
    end else begin
      cyc_cnt   <= next_cyc_cnt;
      us_cnt    <= next_us_cnt;
      power_raw <= next_power_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel filter and tolerance check, evaluated on monitor ticks
  logic [1:0]  raw_in, filt, next_filt;
  logic [7:0]  filt_cnt [2];
  logic [7:0]  next_filt_cnt [2];
  logic [7:0]  filt_lim [2];
  logic [15:0] tol_lim [2];
  logic [15:0] tol_cnt [2];
  logic [15:0] next_tol_cnt [2];
  disc_state_t disc [2];
  disc_state_t next_disc [2];
  logic [1:0]  disc_fault;

  assign raw_in   = {power_raw, ctrl_raw};
  assign filt_lim = '{ctrl_input_filter_time, power_input_filter_time};
  assign tol_lim  = '{ctrl_changeover_tolerance, power_changeover_tolerance};

  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_comb begin
        next_filt[g]     = filt[g];
        next_filt_cnt[g] = filt_cnt[g];
        next_tol_cnt[g]  = tol_cnt[g];
        next_disc[g]     = disc[g];
        if (monitor_tick) begin
          if (raw_in[g] == filt[g]) next_filt_cnt[g] = 8'h00;
          else if (filt_cnt[g] >= filt_lim[g]) begin
            next_filt[g]     = raw_in[g];
            next_filt_cnt[g] = 8'h00;
          end else next_filt_cnt[g] = filt_cnt[g] + 8'h01;
          case (disc[g])
            DISC_IDLE:
              if (next_filt[0] != next_filt[1]) begin
                next_disc[g]    = DISC_WAIT;
                next_tol_cnt[g] = 16'h0000;
              end
            DISC_WAIT:
              if (next_filt[0] == next_filt[1]) next_disc[g] = DISC_IDLE;
              else if (tol_cnt[g] >= tol_lim[g]) next_disc[g] = DISC_FAULT;
              else next_tol_cnt[g] = tol_cnt[g] + 16'h0001;
            DISC_FAULT:
              if (ack_wr && wdata[ACK_FAULTS] && next_filt[0] == next_filt[1])
                next_disc[g] = DISC_IDLE;
            default: next_disc[g] = DISC_IDLE;
          endcase
        end else if (disc[g] == DISC_FAULT && ack_wr && wdata[ACK_FAULTS]
                     && filt[0] == filt[1])
          next_disc[g] = DISC_IDLE;
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          filt[g]     <= 1'b0;
          filt_cnt[g] <= 8'h00;
          tol_cnt[g]  <= 16'h0000;
          disc[g]     <= DISC_IDLE;
        end else begin
          filt[g]     <= next_filt[g];
          filt_cnt[g] <= next_filt_cnt[g];
          tol_cnt[g]  <= next_tol_cnt[g];
          disc[g]     <= next_disc[g];
        end
      end
      assign disc_fault[g] = (disc[g] == DISC_FAULT);
    end
  endgenerate
  assign ctrl_fault  = disc_fault[0];
  assign power_fault = disc_fault[1];

  ////////////////////////////////////////////////////////////////////////////
  // alignment fault, stop outputs and register reads
  stop_out_t next_stop_out;
  logic      selected;

  always_comb begin
    next_monitor_alignment_fault = monitor_alignment_fault;
    if (version_incompatible && commissioning)
      next_monitor_alignment_fault = 1'b1;
    else if (ack_wr && wdata[ACK_FAULTS] && !commissioning)
      next_monitor_alignment_fault = 1'b0;
  end

  // any channel low selects, no waiting for the other
  assign selected = !filt[0] || !filt[1] || !raw_in[0] || !raw_in[1];

  always_comb begin
    next_stop_out = '0;
    next_stop_out.ctrl_discrepancy_fault  = ctrl_fault;
    next_stop_out.power_discrepancy_fault = power_fault;
    next_stop_out.monitor_alignment_fault = next_monitor_alignment_fault;
    next_stop_out.coast_down_reaction     = next_monitor_alignment_fault;
    // only this drive's pulses are touched
    next_stop_out.pulses_enabled = !selected && !commissioning
                                   && !version_incompatible
                                   && !next_monitor_alignment_fault;
    next_stop_out.brake_open = next_stop_out.pulses_enabled
                               || !function_enable[EN_BRAKE_CTRL];
    next_stop_out.brake_test = selected && function_enable[EN_CTRL_BRAKE]
                               && function_enable[EN_POWER_BRAKE];
    if (function_enable[EN_CTRL_BRAKE] && selected)
      next_stop_out.brake_open = 1'b0;
    next_rdata = 16'h0000;
    if (rd) begin
      case (addr)
        ADDR_FUNC_ENABLE: next_rdata = {10'h000, function_enable};
        ADDR_CTRL_TOL:    next_rdata = ctrl_changeover_tolerance;
        ADDR_POWER_TOL:   next_rdata = power_changeover_tolerance;
        ADDR_CTRL_FILT:   next_rdata = {8'h00, ctrl_input_filter_time};
        ADDR_POWER_FILT:  next_rdata = {8'h00, power_input_filter_time};
        ADDR_MODE:        next_rdata = {8'h00, commissioning_mode_select};
        ADDR_SAMPLE_DIV:  next_rdata = {8'h00, sample_div};
        ADDR_STATUS:      next_rdata = {6'h00, stop_out, filt, raw_in[1]};
        ADDR_PARALLEL:    next_rdata = {12'h000, parallel_component_count};
        ADDR_CHECKSUM:    next_rdata = power_reference_checksum;
        ADDR_ACTUAL_SUM:  next_rdata = power_actual_checksum;
        ADDR_ACCEPT_VAL:  next_rdata = accept_value;
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      monitor_alignment_fault <= 1'b0;
      stop_out                <= '0;
      rdata                   <= 16'h0000;
    end else begin
      monitor_alignment_fault <= next_monitor_alignment_fault;
      stop_out                <= next_stop_out;
      rdata                   <= next_rdata;
    end
  end
endmodule : safe_stop_input

//--- rtl/safe_stop_pkg.sv
// shared constants and carriers for the dual-channel safe stop input monitor
package safe_stop_pkg;
  localparam int unsigned CLOCK_HZ           = 25_000_000;
  localparam int unsigned MIN_SAMPLE_US      = 1000;
  localparam int unsigned MIN_SAMPLE_CYCLES  =
    (MIN_SAMPLE_US * (CLOCK_HZ / 1_000_000) + 0) ;
  localparam logic [7:0]  COMMISSION_CODE    = 8'h5f;
  localparam logic [15:0] CHECKSUM_FAULT_VAL = 16'h03e8;
  localparam logic [15:0] DOWNLOAD_FAULT_VAL = 16'h07d4;
  localparam logic [15:0] NO_FAULT_VAL       = 16'h0000;
  localparam int unsigned MAX_PARALLEL       = 12;
  localparam int unsigned DIN_COUNT          = 24;
  localparam logic [5:0]  FUNC_RST           = 6'h00;

  // register offsets
  localparam logic [3:0] ADDR_FUNC_ENABLE    = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TOL       = 4'h1;
  localparam logic [3:0] ADDR_POWER_TOL      = 4'h2;
  localparam logic [3:0] ADDR_CTRL_FILT      = 4'h3;
  localparam logic [3:0] ADDR_POWER_FILT     = 4'h4;
  localparam logic [3:0] ADDR_MODE           = 4'h5;
  localparam logic [3:0] ADDR_SAMPLE_DIV     = 4'h6;
  localparam logic [3:0] ADDR_SELECT_BASE    = 4'h7;
  localparam logic [3:0] ADDR_STATUS         = 4'h8;
  localparam logic [3:0] ADDR_ACK            = 4'h9;
  localparam logic [3:0] ADDR_PARALLEL       = 4'ha;
  localparam logic [3:0] ADDR_CHECKSUM       = 4'hb;
  localparam logic [3:0] ADDR_ACTUAL_SUM     = 4'hc;
  localparam logic [3:0] ADDR_ACCEPT_VAL     = 4'hd;

  // function enable field positions
  localparam int unsigned EN_CTRL_FUNC   = 0;
  localparam int unsigned EN_POWER_FUNC  = 1;
  localparam int unsigned EN_CTRL_BRAKE  = 2;
  localparam int unsigned EN_POWER_BRAKE = 3;
  localparam int unsigned EN_BRAKE_CTRL  = 4;
  localparam int unsigned EN_ACTIVATE    = 5;

  // ack register field positions
  localparam int unsigned ACK_FAULTS     = 0;
  localparam int unsigned ACK_DOWNLOAD   = 1;

  typedef enum logic [2:0] {
    DISC_IDLE  = 3'b001,
    DISC_WAIT  = 3'b010,
    DISC_FAULT = 3'b100
  } disc_state_t;

  typedef struct packed {
    logic        pulses_enabled;
    logic        brake_open;
    logic        brake_test;
    logic        ctrl_discrepancy_fault;
    logic        power_discrepancy_fault;
    logic        monitor_alignment_fault;
    logic        coast_down_reaction;
  } stop_out_t;
endpackage : safe_stop_pkg

//--- verif/dual_channel_safe_stop_input_bench.sv
// self-checking bench for the safe stop input monitor
`timescale 1ns/10ps
module dual_channel_safe_stop_input_bench
  import safe_stop_pkg::*;
;
  logic                 clock;
  logic                 rst;
  logic [DIN_COUNT-1:0] digital_inputs;
  logic                 enable_pulses_terminal;
  logic                 monitor_tick;
  logic                 current_ctrl_tick;
  logic                 version_incompatible;
  logic                 config_download;
  logic [3:0]           addr;
  logic [15:0]          wdata;
  logic                 wr;
  logic                 rd;
  stop_out_t            stop_out;
  logic [15:0]          rdata;
  logic [DIN_COUNT-1:0] ctrl_cmd;
  logic                 power_cmd;
  logic [6:0]           tick_count;
  logic [3:0]           ctrl_count;
  logic [15:0]          v;
  logic [15:0]          sum;
  int                   fail_count;
  int                   checked;

  safe_stop_input i_safe_stop_input (
    .clock(clock), .rst(rst), .digital_inputs(digital_inputs),
    .enable_pulses_terminal(enable_pulses_terminal), .monitor_tick(monitor_tick),
    .current_ctrl_tick(current_ctrl_tick), .version_incompatible(version_incompatible),
    .config_download(config_download), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .stop_out(stop_out), .rdata(rdata));
  safe_switch_model i_safe_switch_model (
    .clock(clock), .ctrl_cmd(ctrl_cmd), .power_cmd(power_cmd),
    .digital_inputs(digital_inputs), .enable_pulses_terminal(enable_pulses_terminal));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    tick_count        <= (tick_count == 7'h63) ? 7'h00 : tick_count + 7'h01;
    monitor_tick      <= (tick_count == 7'h63);
    ctrl_count        <= (ctrl_count == 4'h9) ? 4'h0 : ctrl_count + 4'h1;
    current_ctrl_tick <= (ctrl_count == 4'h9);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic check_bit(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask : check_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic wait_bit(input int b, input logic val, input int limit);
    int n;
    n = 0;
    while (stop_out[b] !== val && n < limit) begin
      cyc(1);
      n++;
    end
    if (n == limit) begin
      fail_count++;
      end_sim();
    end
  endtask : wait_bit

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_registers();
    rd_reg(ADDR_SAMPLE_DIV, v);  check(v, 16'h0001);
    rd_reg(ADDR_PARALLEL, v);    check(v, 16'h0001);
    rd_reg(ADDR_FUNC_ENABLE, v); check(v, 16'h0000);
    wr_reg(4'hf, 16'h1234);
    rd_reg(4'hf, v);             check(v, 16'h0000);
  endtask : t_registers
  task automatic t_deselect();
    wr_reg(ADDR_SELECT_BASE, 16'h0003);
    wr_reg(ADDR_CTRL_FILT, 16'h0001);
    wr_reg(ADDR_POWER_FILT, 16'h0001);
    wr_reg(ADDR_CTRL_TOL, 16'h0004);
    wr_reg(ADDR_POWER_TOL, 16'h0004);
    wr_reg(ADDR_FUNC_ENABLE, 16'h0003);
    ctrl_cmd  <= '1;
    power_cmd <= 1'b1;
    wait_bit(6, 1'b1, 60000);
    check_bit(stop_out.power_discrepancy_fault, 1'b1);
    wr_reg(ADDR_ACK, 16'h0001);
    cyc(2);
    check_bit(stop_out.power_discrepancy_fault, 1'b0);
    rd_reg(ADDR_STATUS, v); check(v, 16'h0307);
  endtask : t_deselect
  task automatic t_one_channel();
    ctrl_cmd[3] <= 1'b0;
    cyc(3);
    check_bit(stop_out.pulses_enabled, 1'b0);
    cyc(200);
    check_bit(stop_out.ctrl_discrepancy_fault, 1'b0);
    wait_bit(3, 1'b1, 2000);
    wr_reg(ADDR_ACK, 16'h0001);
    cyc(2);
    check_bit(stop_out.ctrl_discrepancy_fault, 1'b1);
    ctrl_cmd[3] <= 1'b1;
    cyc(500);
    wr_reg(ADDR_ACK, 16'h0001);
    cyc(2);
    check_bit(stop_out.ctrl_discrepancy_fault, 1'b0);
    wait_bit(6, 1'b1, 3000);
  endtask : t_one_channel
  task automatic t_parallel();
    wr_reg(ADDR_FUNC_ENABLE, 16'h000f);
    wr_reg(ADDR_PARALLEL, 16'h0002);
    wr_reg(ADDR_SELECT_BASE, 16'h1007);
    wr_reg(ADDR_PARALLEL, 16'h000d);
    rd_reg(ADDR_PARALLEL, v); check(v, 16'h0002);
    ctrl_cmd[9] <= 1'b0;
    cyc(4);
    check_bit(stop_out.pulses_enabled, 1'b1);
    ctrl_cmd[9] <= 1'b1;
    ctrl_cmd[7] <= 1'b0;
    cyc(3);
    check_bit(stop_out.pulses_enabled, 1'b0);
    check_bit(stop_out.brake_test, 1'b1);
    check_bit(stop_out.brake_open, 1'b0);
    cyc(20);
    ctrl_cmd[7] <= 1'b1;
    cyc(1000);
    check_bit(stop_out.ctrl_discrepancy_fault, 1'b0);
    wait_bit(6, 1'b1, 3000);
  endtask : t_parallel
  task automatic t_version();
    @(posedge clock);
    version_incompatible <= 1'b1;
    wr_reg(ADDR_FUNC_ENABLE, 16'h001f);
    rd_reg(ADDR_FUNC_ENABLE, v); check(v, 16'h0010);
    wr_reg(ADDR_MODE, 16'h005f);
    wait_bit(1, 1'b1, 10);
    check_bit(stop_out.coast_down_reaction, 1'b1);
    check_bit(stop_out.pulses_enabled, 1'b0);
    check_bit(stop_out.brake_open, 1'b0);
    wr_reg(ADDR_ACK, 16'h0001);
    cyc(2);
    check_bit(stop_out.monitor_alignment_fault, 1'b1);
    wr_reg(ADDR_MODE, 16'h0000);
    version_incompatible <= 1'b0;
    wr_reg(ADDR_ACK, 16'h0001);
    cyc(2);
    check_bit(stop_out.monitor_alignment_fault, 1'b0);
  endtask : t_version
  task automatic t_acceptance();
    wr_reg(ADDR_FUNC_ENABLE, 16'h0023);
    rd_reg(ADDR_ACTUAL_SUM, sum);
    rd_reg(ADDR_CHECKSUM, v); check(v, sum);
    @(posedge clock);
    config_download <= 1'b1;
    @(posedge clock);
    config_download <= 1'b0;
    rd_reg(ADDR_ACCEPT_VAL, v); check(v, 16'h07d4);
    wr_reg(ADDR_ACK, 16'h0002);
    rd_reg(ADDR_ACCEPT_VAL, v); check(v, 16'h0000);
    wr_reg(ADDR_CHECKSUM, sum ^ 16'h0001);
    rd_reg(ADDR_CHECKSUM, v); check(v, sum);
    wr_reg(ADDR_MODE, 16'h005f);
    wr_reg(ADDR_CHECKSUM, sum ^ 16'h0001);
    wr_reg(ADDR_MODE, 16'h0000);
    rd_reg(ADDR_ACCEPT_VAL, v); check(v, 16'h03e8);
  endtask : t_acceptance

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    version_incompatible = 1'b0;
    config_download = 1'b0;
    ctrl_cmd = '0;
    power_cmd = 1'b0;
    tick_count = 7'h00;
    ctrl_count = 4'h0;
    monitor_tick = 1'b0;
    current_ctrl_tick = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_registers();
    t_deselect();
    t_one_channel();
    t_parallel();
    t_version();
    t_acceptance();
    end_sim();
  end
endmodule : dual_channel_safe_stop_input_bench

//--- verif/safe_stop_props.sv
// concurrent checks on the ports of the safe stop input monitor
`timescale 1ns/10ps
module safe_stop_props
  import safe_stop_pkg::*;
#(
  parameter int unsigned DIN_WIDTH = DIN_COUNT
) (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic [DIN_WIDTH-1:0] digital_inputs,
  input wire logic                 monitor_tick,
  input wire logic                 version_incompatible,
  input wire logic [3:0]           addr,
  input wire logic [15:0]          wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire stop_out_t            stop_out,
  input wire logic [15:0]          rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (
    $fell(rst) |-> stop_out == '0 && rdata == 16'h0000) else $error("outputs live after reset");
  a_read_idle: assert property (
    !$past(rd) |-> rdata == 16'h0000) else $error("read data outside read cycle");
  a_unmapped_zero: assert property (
    rd && addr > ADDR_ACCEPT_VAL |=> rdata == 16'h0000) else $error("unmapped read not zero");
  a_all_low_stop: assert property (
    digital_inputs == '0 |=> !stop_out.pulses_enabled) else $error("pulses kept on selection");
  a_incompat_off: assert property (
    version_incompatible |=> !stop_out.pulses_enabled) else $error("pulses on while incompatible");
  a_align_coast: assert property (
    $rose(stop_out.monitor_alignment_fault) |-> ##[0:2] stop_out.coast_down_reaction)
    else $error("alignment fault without coast down");
  a_align_no_pulse: assert property (
    stop_out.monitor_alignment_fault |-> !stop_out.pulses_enabled)
    else $error("pulses on with alignment fault");
  a_mode_entry: assert property (
    wr && addr == ADDR_MODE && wdata[7:0] == COMMISSION_CODE && version_incompatible
    |-> ##[1:4] stop_out.monitor_alignment_fault) else $error("no alignment fault on mode entry");
  a_align_held: assert property (
    stop_out.monitor_alignment_fault && !(wr && addr == ADDR_ACK)
    |=> stop_out.monitor_alignment_fault) else $error("alignment fault dropped without ack");
  a_disc_held: assert property (
    stop_out.ctrl_discrepancy_fault && !(wr && addr == ADDR_ACK)
    && !($past(wr) && $past(addr) == ADDR_ACK)
    |=> stop_out.ctrl_discrepancy_fault) else $error("discrepancy fault dropped without ack");
  a_fault_on_tick: assert property (
    $rose(stop_out.ctrl_discrepancy_fault) || $rose(stop_out.power_discrepancy_fault)
    |-> $past(monitor_tick) || $past(monitor_tick, 2)) else $error("fault raised off tick");
endmodule : safe_stop_props

bind safe_stop_input safe_stop_props #(.DIN_WIDTH(DIN_WIDTH)) i_safe_stop_props (
  .clock(clock), .rst(rst), .digital_inputs(digital_inputs), .monitor_tick(monitor_tick),
  .version_incompatible(version_incompatible), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .stop_out(stop_out), .rdata(rdata));

//--- verif/safe_switch_model.sv
// external safety switching device driving both input channels
`timescale 1ns/10ps
module safe_switch_model
  import safe_stop_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic [DIN_COUNT-1:0] ctrl_cmd,
  input  wire logic                 power_cmd,
  output logic      [DIN_COUNT-1:0] digital_inputs,
  output logic                      enable_pulses_terminal
);
  // both paths switch on one edge, all digital inputs on one path, the single terminal on the other
  always_ff @(posedge clock) begin
    digital_inputs         <= ctrl_cmd;
    enable_pulses_terminal <= power_cmd;
  end
endmodule : safe_switch_model
